// >>> design/ptpts_capture.sv
// ptpts_capture: one egress timestamp holder with its ready flag.
// assumes: fire is a one-cycle pulse on ref_clk, clr from a bus write.
`timescale 1ns/1ps
module ptpts_capture
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        fire,
  input  wire logic [31:0] time_in,
  input  wire logic        clr,
  output logic      [31:0] ts_q,
  output logic             flag_q
);
  import ptpts_pkg::*;

  // value held until the next frame of the same kind
  always_ff @(posedge ref_clk)
    if (srst)
      ts_q <= RST_TS;
    else if (fire)
      ts_q <= time_in;

  // set wins over a clear in the same cycle
  always_ff @(posedge ref_clk)
    if (srst)
      flag_q <= 1'h0;
    else if (fire)
      flag_q <= 1'h1;
    else if (clr)
      flag_q <= 1'h0;

endmodule

// >>> design/ptpts_corr.sv
// ptpts_corr: latency compensation and asymmetry correction of one port.
// assumes: all inputs on ref_clk; one result per valid, one cycle later.
`timescale 1ns/1ps
module ptpts_corr
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic [15:0] rx_lat,
  input  wire logic [15:0] tx_lat,
  input  wire logic [15:0] asym,
  input  wire logic        rx_valid,
  input  wire logic [31:0] rx_raw,
  input  wire logic        tx_valid,
  input  wire logic [3:0]  tx_msg,
  input  wire logic [31:0] tx_raw,
  input  wire logic        cf_valid,
  input  wire logic        cf_egress,
  input  wire logic [3:0]  cf_msg,
  input  wire logic [63:0] cf_in,
  output logic             rx_valid_q,
  output logic      [31:0] rx_wire_q,
  output logic             tx_valid_q,
  output logic      [3:0]  tx_msg_q,
  output logic      [31:0] tx_wire_q,
  output logic             cf_valid_q,
  output logic      [63:0] cf_out_q
);
  import ptpts_pkg::*;

  logic [63:0] asym_cf;
  logic        neg;
  logic        ing_msg;
  logic        egr_msg;
  logic        do_add;
  logic        do_sub;

  assign asym_cf = 64'(asym[14:0]) << CORR_FRAC;
  assign neg     = asym[ASYM_SIGN_BIT];
  assign ing_msg = !cf_egress && (cf_msg == MSG_SYNC || cf_msg == MSG_PDELAY_RSP);
  assign egr_msg = cf_egress && (cf_msg == MSG_DELAY_REQ || cf_msg == MSG_PDELAY_REQ);
  assign do_add  = (ing_msg && !neg) || (egr_msg && neg);
  assign do_sub  = (ing_msg && neg) || (egr_msg && !neg);

  // wire-referred times
  always_ff @(posedge ref_clk)
    if (srst)
    begin
      rx_valid_q <= 1'h0;
      rx_wire_q  <= RST_TS;
      tx_valid_q <= 1'h0;
      tx_msg_q   <= 4'h0;
      tx_wire_q  <= RST_TS;
    end
    else
    begin
      rx_valid_q <= rx_valid;
      rx_wire_q  <= rx_raw - {16'h0, rx_lat};
      tx_valid_q <= tx_valid;
      tx_msg_q   <= tx_msg;
      tx_wire_q  <= tx_raw + {16'h0, tx_lat};
    end

  // correction field update
  always_ff @(posedge ref_clk)
    if (srst)
    begin
      cf_valid_q <= 1'h0;
      cf_out_q   <= 64'h0;
    end
    else
    begin
      cf_valid_q <= cf_valid;
      if (do_add)
        cf_out_q <= cf_in + asym_cf;
      else if (do_sub)
        cf_out_q <= cf_in - asym_cf;
      else
        cf_out_q <= cf_in;
    end

endmodule

// >>> design/ptpts_pkg.sv
// ptpts_pkg: register map, reset values and message codes for the
// per-port ptp timestamp register bank.
// assumes: word-indexed registers, byte address = 4 * index.
package ptpts_pkg;

  localparam int          ADDR_W         = 18;
  localparam int          CORR_FRAC      = 16;

  // register indices within a port window (index = {port, offset})
  localparam logic [11:0] OFF_RX_LAT     = 12'hc00;
  localparam logic [11:0] OFF_TX_LAT     = 12'hc02;
  localparam logic [11:0] OFF_ASYM       = 12'hc04;
  localparam logic [11:0] OFF_DREQ_HI    = 12'hc08;
  localparam logic [11:0] OFF_DREQ_LO    = 12'hc0a;
  localparam logic [11:0] OFF_SYNC_HI    = 12'hc0c;
  localparam logic [11:0] OFF_SYNC_LO    = 12'hc0e;
  localparam logic [11:0] OFF_PRSP_HI    = 12'hc10;
  localparam logic [11:0] OFF_PRSP_LO    = 12'hc12;
  localparam logic [11:0] OFF_FLAG       = 12'hc14;
  localparam logic [11:0] OFF_ENB        = 12'hc16;
  localparam logic [11:0] OFF_LINK       = 12'hc18;
  localparam logic [11:0] OFF_SUMMARY    = 12'hc1c;

  // reset values
  localparam logic [15:0] RST_RX_LAT     = 16'h019f;
  localparam logic [15:0] RST_TX_LAT     = 16'h002d;
  localparam logic [15:0] RST_ASYM       = 16'h0000;
  localparam logic [31:0] RST_TS         = 32'h0000_0000;
  localparam logic [31:0] RST_LINK       = 32'h0000_0000;
  localparam logic [2:0]  RST_ENB        = 3'h0;

  // field positions
  localparam int          ASYM_SIGN_BIT  = 15;
  localparam int          FLAG_LSB       = 13;
  localparam int          SUM_PTP_BIT    = 0;

  // capture slots, flag bit = FLAG_LSB + slot
  localparam int          SLOT_PRSP      = 0;
  localparam int          SLOT_DREQ      = 1;
  localparam int          SLOT_SYNC      = 2;
  localparam int          NSLOT          = 3;

  // ptp messageType codes
  localparam logic [3:0]  MSG_SYNC       = 4'h0;
  localparam logic [3:0]  MSG_DELAY_REQ  = 4'h1;
  localparam logic [3:0]  MSG_PDELAY_REQ = 4'h2;
  localparam logic [3:0]  MSG_PDELAY_RSP = 4'h3;

endpackage

// >>> design/ptpts_top.sv
// ptpts_top: per-port ptp timestamp register bank behind an avalon-mm slave.
// assumes: one clock, frame-side strobes synchronous to ref_clk.
`timescale 1ns/1ps
module ptpts_top
#(
  parameter int NPORT = 3
)
(
  input  wire logic                         ref_clk,
  input  wire logic                         srst,
  input  wire logic [ptpts_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [31:0]                  avs_writedata,
  input  wire logic [3:0]                   avs_byteenable,
  output logic      [31:0]                  avs_readdata,
  output logic                              avs_waitrequest,
  input  wire logic [NPORT-1:0]             tx_evt_valid,
  input  wire logic [NPORT-1:0][3:0]        tx_evt_msg,
  input  wire logic [NPORT-1:0][31:0]       tx_evt_time,
  input  wire logic [NPORT-1:0]             rx_ts_valid,
  input  wire logic [NPORT-1:0][31:0]       rx_ts_raw,
  output logic      [NPORT-1:0]             rx_ts_wire_valid,
  output logic      [NPORT-1:0][31:0]       rx_ts_wire,
  input  wire logic [NPORT-1:0]             cf_valid,
  input  wire logic [NPORT-1:0]             cf_egress,
  input  wire logic [NPORT-1:0][3:0]        cf_msg,
  input  wire logic [NPORT-1:0][63:0]       cf_in,
  output logic      [NPORT-1:0]             cf_out_valid,
  output logic      [NPORT-1:0][63:0]       cf_out,
  output logic      [NPORT-1:0]             ptp_summary
);
  import ptpts_pkg::*;

  if (NPORT < 1 || NPORT > 3)
  begin : g_bad_nport
    $error("ptpts_top: NPORT must be 1 to 3");
  end

  logic [15:0]      rx_lat_q [NPORT];
  logic [15:0]      tx_lat_q [NPORT];
  logic [15:0]      asym_q   [NPORT];
  logic [2:0]       enb_q    [NPORT];
  logic [31:0]      link_q   [NPORT];
  logic [31:0]      ts_w     [NPORT][NSLOT];
  logic [NSLOT-1:0] flag_w   [NPORT];
  logic [NPORT-1:0] summary_q;
  logic             wait_q;
  logic [31:0]      rdata_q;
  logic [31:0]      rd_d;
  logic [15:0]      idx;
  logic [3:0]       sel_port;
  logic [11:0]      sel_off;
  logic [1:0]       pi;
  logic             hit;
  logic             wr_fire;
  logic [63:0]      asym_step;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic logic [31:0] merge32(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    merge32 = old;
    for (int b = 0; b < 4; b++)
      if (be[b])
        merge32[8*b +: 8] = wd[8*b +: 8];
  endfunction

  // address decode: byte address = 4 * {port, offset}
  assign idx      = avs_address[ADDR_W-1:2];
  assign sel_port = idx[15:12];
  assign sel_off  = idx[11:0];
  assign hit      = (sel_port != 4'h0) && (sel_port <= 4'(NPORT));
  assign pi       = 2'(sel_port - 4'h1);
  assign wr_fire  = avs_write && !wait_q && hit;

  // waitrequest low for one cycle after a request is seen
  always_ff @(posedge ref_clk)
    if (srst)
      wait_q <= 1'h1;
    else if (!wait_q)
      wait_q <= 1'h1;
    else if (avs_read || avs_write)
      wait_q <= 1'h0;

  always_comb
  begin
    rd_d = 32'h0;
    if (hit)
      case (sel_off)
        OFF_RX_LAT:  rd_d = {16'h0, rx_lat_q[pi]};
        OFF_TX_LAT:  rd_d = {16'h0, tx_lat_q[pi]};
        OFF_ASYM:    rd_d = {16'h0, asym_q[pi]};
        OFF_DREQ_HI: rd_d = {16'h0, ts_w[pi][SLOT_DREQ][31:16]};
        OFF_DREQ_LO: rd_d = {16'h0, ts_w[pi][SLOT_DREQ][15:0]};
        OFF_SYNC_HI: rd_d = {16'h0, ts_w[pi][SLOT_SYNC][31:16]};
        OFF_SYNC_LO: rd_d = {16'h0, ts_w[pi][SLOT_SYNC][15:0]};
        OFF_PRSP_HI: rd_d = {16'h0, ts_w[pi][SLOT_PRSP][31:16]};
        OFF_PRSP_LO: rd_d = {16'h0, ts_w[pi][SLOT_PRSP][15:0]};
        OFF_FLAG:    rd_d = {16'h0, flag_w[pi], 13'h0};
        OFF_ENB:     rd_d = {16'h0, enb_q[pi], 13'h0};
        OFF_LINK:    rd_d = link_q[pi];
        OFF_SUMMARY: rd_d = {31'h0, summary_q[pi]};
        default:     rd_d = 32'h0;
      endcase
  end

  always_ff @(posedge ref_clk)
    if (srst)
      rdata_q <= 32'h0;
    else if (avs_read && wait_q)
      rdata_q <= rd_d;

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign ptp_summary     = summary_q;

  for (genvar p = 0; p < NPORT; p++)
  begin : g_port
    logic             tx_v;
    logic [3:0]       tx_m;
    logic [31:0]      tx_t;
    logic [NSLOT-1:0] fire;
    logic [NSLOT-1:0] clr;
    logic             wsel;

    assign wsel = wr_fire && (pi == 2'(p));

    // software-written settings
    always_ff @(posedge ref_clk)
      if (srst)
      begin
        rx_lat_q[p] <= RST_RX_LAT;
        tx_lat_q[p] <= RST_TX_LAT;
        asym_q[p]   <= RST_ASYM;
        enb_q[p]    <= RST_ENB;
        link_q[p]   <= RST_LINK;
      end
      else if (wsel)
        case (sel_off)
          OFF_RX_LAT: rx_lat_q[p] <= merge16(rx_lat_q[p], avs_writedata, avs_byteenable);
          OFF_TX_LAT: tx_lat_q[p] <= merge16(tx_lat_q[p], avs_writedata, avs_byteenable);
          OFF_ASYM:   asym_q[p]   <= merge16(asym_q[p], avs_writedata, avs_byteenable);
          OFF_ENB:
            if (avs_byteenable[1])
              enb_q[p] <= avs_writedata[15:13];
          OFF_LINK:   link_q[p]   <= merge32(link_q[p], avs_writedata, avs_byteenable);
          default:    link_q[p]   <= link_q[p];
        endcase

    ptpts_corr u_corr (
      .ref_clk    (ref_clk),
      .srst       (srst),
      .rx_lat     (rx_lat_q[p]),
      .tx_lat     (tx_lat_q[p]),
      .asym       (asym_q[p]),
      .rx_valid   (rx_ts_valid[p]),
      .rx_raw     (rx_ts_raw[p]),
      .tx_valid   (tx_evt_valid[p]),
      .tx_msg     (tx_evt_msg[p]),
      .tx_raw     (tx_evt_time[p]),
      .cf_valid   (cf_valid[p]),
      .cf_egress  (cf_egress[p]),
      .cf_msg     (cf_msg[p]),
      .cf_in      (cf_in[p]),
      .rx_valid_q (rx_ts_wire_valid[p]),
      .rx_wire_q  (rx_ts_wire[p]),
      .tx_valid_q (tx_v),
      .tx_msg_q   (tx_m),
      .tx_wire_q  (tx_t),
      .cf_valid_q (cf_out_valid[p]),
      .cf_out_q   (cf_out[p])
    );

    // sort transmitted event frames into their capture slots
    assign fire[SLOT_SYNC] = tx_v && (tx_m == MSG_SYNC);
    assign fire[SLOT_DREQ] = tx_v && (tx_m == MSG_DELAY_REQ || tx_m == MSG_PDELAY_REQ);
    assign fire[SLOT_PRSP] = tx_v && (tx_m == MSG_PDELAY_RSP);
    assign clr = (wsel && sel_off == OFF_FLAG && avs_byteenable[1]) ?
                 avs_writedata[FLAG_LSB +: NSLOT] : '0;

    for (genvar k = 0; k < NSLOT; k++)
    begin : g_slot
      ptpts_capture u_cap (
        .ref_clk (ref_clk),
        .srst    (srst),
        .fire    (fire[k]),
        .time_in (tx_t),
        .clr     (clr[k]),
        .ts_q    (ts_w[p][k]),
        .flag_q  (flag_w[p][k])
      );
    end

    always_ff @(posedge ref_clk)
      if (srst)
        summary_q[p] <= 1'h0;
      else
        summary_q[p] <= |flag_w[p];
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  sequence s_tx_evt(logic [3:0] m);
    tx_evt_valid[0] && tx_evt_msg[0] == m;
  endsequence

  sequence s_cap_ok(int k);
    ##2 (ts_w[0][k] == 32'($past(tx_evt_time[0], 2) + {16'h0, $past(tx_lat_q[0], 2)}));
  endsequence

  sequence s_cf_rx(logic [3:0] m);
    cf_valid[0] && !cf_egress[0] && cf_msg[0] == m;
  endsequence

  sequence s_cf_tx(logic [3:0] m);
    cf_valid[0] && cf_egress[0] && cf_msg[0] == m;
  endsequence

  assign asym_step = {33'h0, asym_q[0][14:0], 16'h0};

  a_reset_values: assert property ($past(srst) |-> rx_lat_q[0] == RST_RX_LAT
    && tx_lat_q[0] == RST_TX_LAT && asym_q[0] == RST_ASYM && enb_q[0] == RST_ENB)
    else $error("settings not at reset values");
  a_asym_write: assert property (wr_fire && pi == 2'h0 && sel_off == OFF_ASYM
    && avs_byteenable == 4'hf |=> asym_q[0] == $past(avs_writedata[15:0]))
    else $error("asymmetry write lost");
  a_rx_lat_write: assert property (wr_fire && pi == 2'h0 && sel_off == OFF_RX_LAT
    && avs_byteenable == 4'hf |=> rx_lat_q[0] == $past(avs_writedata[15:0]))
    else $error("rx latency write lost");
  a_tx_lat_write: assert property (wr_fire && pi == 2'h0 && sel_off == OFF_TX_LAT
    && avs_byteenable == 4'hf |=> tx_lat_q[0] == $past(avs_writedata[15:0]))
    else $error("tx latency write lost");
  a_enb_write: assert property (wr_fire && pi == 2'h0 && sel_off == OFF_ENB
    && avs_byteenable[1] |=> enb_q[0] == $past(avs_writedata[15:13]))
    else $error("enable write lost");
  a_cf_ingress: assert property (s_cf_rx(MSG_SYNC)
    |=> cf_out[0] == ($past(asym_q[0][15]) ? $past(cf_in[0] - asym_step)
                                           : $past(cf_in[0] + asym_step)))
    else $error("ingress correction wrong");
  a_cf_prsp_in: assert property (s_cf_rx(MSG_PDELAY_RSP)
    |=> cf_out[0] == ($past(asym_q[0][15]) ? $past(cf_in[0] - asym_step)
                                           : $past(cf_in[0] + asym_step)))
    else $error("peer response correction wrong");
  a_cf_egress: assert property (s_cf_tx(MSG_DELAY_REQ)
    |=> cf_out[0] == ($past(asym_q[0][15]) ? $past(cf_in[0] + asym_step)
                                           : $past(cf_in[0] - asym_step)))
    else $error("egress correction wrong");
  a_cf_pdreq_out: assert property (s_cf_tx(MSG_PDELAY_REQ)
    |=> cf_out[0] == ($past(asym_q[0][15]) ? $past(cf_in[0] + asym_step)
                                           : $past(cf_in[0] - asym_step)))
    else $error("peer request correction wrong");
  a_cf_pass: assert property (s_cf_rx(MSG_DELAY_REQ)
    |=> cf_out[0] == $past(cf_in[0]))
    else $error("uncorrected message changed");
  a_dly_capture: assert property (s_tx_evt(MSG_DELAY_REQ) |-> s_cap_ok(SLOT_DREQ))
    else $error("delay request stamp missing");
  a_dreq_capture: assert property (s_tx_evt(MSG_PDELAY_REQ)
    |-> s_cap_ok(SLOT_DREQ))
    else $error("delay request time not captured");
  a_sync_capture: assert property (s_tx_evt(MSG_SYNC) |-> s_cap_ok(SLOT_SYNC))
    else $error("sync time not captured");
  a_prsp_capture: assert property (s_tx_evt(MSG_PDELAY_RSP)
    |-> s_cap_ok(SLOT_PRSP))
    else $error("peer response time not captured");
  a_flag_set: assert property (s_tx_evt(MSG_SYNC) |-> ##2 flag_w[0][SLOT_SYNC])
    else $error("sync ready flag not set");
  a_flag_clear: assert property (wr_fire && pi == 2'h0 && sel_off == OFF_FLAG
    && avs_byteenable[1] && avs_writedata[15] && !$past(tx_evt_valid[0])
    |=> !flag_w[0][SLOT_SYNC])
    else $error("sync ready flag not cleared");
  a_summary_or: assert property (ptp_summary[0] == $past(|flag_w[0]))
    else $error("summary bit not OR of flags");
  a_link_write: assert property (wr_fire && pi == 2'h0 && sel_off == OFF_LINK
    && avs_byteenable == 4'hf |=> link_q[0] == $past(avs_writedata))
    else $error("link delay write lost");
  a_rx_comp: assert property (rx_ts_valid[0] |=> rx_ts_wire_valid[0]
    && rx_ts_wire[0] == 32'($past(rx_ts_raw[0]) - {16'h0, $past(rx_lat_q[0])}))
    else $error("rx time not compensated");
  a_ts_hold: assert property (!tx_evt_valid[0] ##1 !tx_evt_valid[0]
    |=> $stable(ts_w[0][SLOT_SYNC]))
    else $error("sync time changed without frame");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not in one cycle");

endmodule

// >>> tb/ptpts_link_partner.sv
// ptpts_link_partner: frame-side model, one event, stamp or correction per call.
// assumes: ref_clk from the bench; lines flip after each pulse so stale data never looks valid.
`timescale 1ns/1ps
module ptpts_link_partner
#(
  parameter int NPORT = 3
)
(
  input  wire logic                   ref_clk,
  output logic      [NPORT-1:0]       tx_evt_valid,
  output logic      [NPORT-1:0][3:0]  tx_evt_msg,
  output logic      [NPORT-1:0][31:0] tx_evt_time,
  output logic      [NPORT-1:0]       rx_ts_valid,
  output logic      [NPORT-1:0][31:0] rx_ts_raw,
  output logic      [NPORT-1:0]       cf_valid,
  output logic      [NPORT-1:0]       cf_egress,
  output logic      [NPORT-1:0][3:0]  cf_msg,
  output logic      [NPORT-1:0][63:0] cf_in
);
  initial
  begin
    {tx_evt_valid, tx_evt_msg, tx_evt_time, rx_ts_valid, rx_ts_raw} = '0;
    {cf_valid, cf_egress, cf_msg, cf_in} = '0;
  end

  // one-cycle transmit event pulse
  task automatic send_tx(input int p, input logic [3:0] msg, input logic [31:0] t);
    @(posedge ref_clk);
    tx_evt_valid[p] <= 1'b1;
    tx_evt_msg[p]   <= msg;
    tx_evt_time[p]  <= t;
    @(posedge ref_clk);
    tx_evt_valid[p] <= 1'b0;
    tx_evt_msg[p]   <= ~msg;
    tx_evt_time[p]  <= ~t;
  endtask

  // one-cycle receive stamp pulse
  task automatic send_rx(input int p, input logic [31:0] t);
    @(posedge ref_clk);
    rx_ts_valid[p] <= 1'b1;
    rx_ts_raw[p]   <= t;
    @(posedge ref_clk);
    rx_ts_valid[p] <= 1'b0;
    rx_ts_raw[p]   <= ~t;
  endtask

  // one-cycle correction field pulse
  task automatic send_cf(input int p, input logic eg, input logic [3:0] msg,
                         input logic [63:0] cf);
    @(posedge ref_clk);
    cf_valid[p]  <= 1'b1;
    cf_egress[p] <= eg;
    cf_msg[p]    <= msg;
    cf_in[p]     <= cf;
    @(posedge ref_clk);
    cf_valid[p]  <= 1'b0;
    cf_egress[p] <= ~eg;
    cf_msg[p]    <= ~msg;
    cf_in[p]     <= ~cf;
  endtask
endmodule

// >>> tb/test_ptpts_top.sv
// test_ptpts_top: register, capture and correction tests of the ptp bank.
// assumes: partner model drives the frame side, the bench owns the avalon bus.
`timescale 1ns/1ps
module test_ptpts_top;
  import ptpts_pkg::*;
  localparam int NP = 3;
  logic                ref_clk;
  logic                srst;
  logic [ADDR_W-1:0]   avs_address;
  logic                avs_read;
  logic                avs_write;
  logic [31:0]         avs_writedata;
  logic [3:0]          avs_byteenable;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  logic [NP-1:0]       tx_evt_valid;
  logic [NP-1:0][3:0]  tx_evt_msg;
  logic [NP-1:0][31:0] tx_evt_time;
  logic [NP-1:0]       rx_ts_valid;
  logic [NP-1:0][31:0] rx_ts_raw;
  logic [NP-1:0]       rx_ts_wire_valid;
  logic [NP-1:0][31:0] rx_ts_wire;
  logic [NP-1:0]       cf_valid;
  logic [NP-1:0]       cf_egress;
  logic [NP-1:0][3:0]  cf_msg;
  logic [NP-1:0][63:0] cf_in;
  logic [NP-1:0]       cf_out_valid;
  logic [NP-1:0][63:0] cf_out;
  logic [NP-1:0]       ptp_summary;
  int                  n_errors;
  int                  comparisons;

  ptpts_top #(.NPORT(NP)) i_ptpts_top (.ref_clk, .srst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .tx_evt_valid,
    .tx_evt_msg, .tx_evt_time, .rx_ts_valid, .rx_ts_raw, .rx_ts_wire_valid, .rx_ts_wire,
    .cf_valid, .cf_egress, .cf_msg, .cf_in, .cf_out_valid, .cf_out, .ptp_summary);

  ptpts_link_partner #(.NPORT(NP)) i_ptpts_link_partner (.ref_clk, .tx_evt_valid,
    .tx_evt_msg, .tx_evt_time, .rx_ts_valid, .rx_ts_raw, .cf_valid, .cf_egress, .cf_msg,
    .cf_in);

  task automatic give_verdict();
    if (n_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input int p, input logic [11:0] off,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge ref_clk);
    avs_address   <= {p[3:0], off, 2'b00};
    avs_writedata <= wd;
    avs_write     <= w;
    avs_read      <= !w;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0)
      n_errors++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input int p, input logic [11:0] off, input logic [31:0] wd);
    logic [31:0] rd;
    bus(1'b1, p, off, wd, rd);
  endtask

  task automatic rdchk(input int p, input logic [11:0] off, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, p, off, 32'h0, rd);
    check(rd, exp);
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    give_verdict();
  end

  initial
  begin
    logic [31:0] tl;
    logic [31:0] e;
    logic [15:0] fl;
    logic [15:0] asym;
    logic [11:0] hi;
    logic [3:0]  msgs [4];
    int          s;
    int          d;
    msgs = '{MSG_SYNC, MSG_DELAY_REQ, MSG_PDELAY_REQ, MSG_PDELAY_RSP};
    n_errors = 0;
    comparisons = 0;
    srst = 1'b1;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    avs_byteenable = 4'hf;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    for (int p = 1; p <= NP; p++)
    begin
      rdchk(p, OFF_RX_LAT, 32'h0000_019f);
      rdchk(p, OFF_TX_LAT, 32'h0000_002d);
      rdchk(p, OFF_ASYM, 32'h0);
      for (int k = 0; k < 6; k++)
        rdchk(p, OFF_DREQ_HI + 12'(2 * k), 32'h0);
      rdchk(p, OFF_FLAG, 32'h0);
      rdchk(p, OFF_ENB, 32'h0);
      rdchk(p, OFF_LINK, 32'h0);
      rdchk(p, OFF_SUMMARY, 32'h0);
    end
    // read-write access, upper bits of half-word registers read zero
    for (int p = 1; p <= NP; p++)
    begin
      for (int r = 0; r < 3; r++)
      begin
        wr(p, OFF_RX_LAT + 12'(2 * r), 32'hffff_a5a0 + p);
        rdchk(p, OFF_RX_LAT + 12'(2 * r), 32'h0000_a5a0 + p);
      end
      wr(p, OFF_ENB, 32'hffff_ffff);
      rdchk(p, OFF_ENB, 32'h0000_e000);
      wr(p, OFF_LINK, 32'hdead_be00 + p);
      rdchk(p, OFF_LINK, 32'hdead_be00 + p);
      avs_byteenable <= 4'h3;
      wr(p, OFF_LINK, 32'h1111_2222);
      avs_byteenable <= 4'hf;
      rdchk(p, OFF_LINK, 32'hdead_2222);
      wr(p, OFF_SYNC_HI, 32'h0000_1234);
      rdchk(p, OFF_SYNC_HI, 32'h0);
    end
    wr(0, OFF_RX_LAT, 32'h0000_1111);
    rdchk(0, OFF_RX_LAT, 32'h0);
    rdchk(1, OFF_RX_LAT, 32'h0000_a5a1);
    rdchk(1, 12'hc06, 32'h0);
    // egress capture, ready flags, write-one-clear, summary
    for (int p = 1; p <= NP; p++)
    begin
      tl = 32'h0000_0100 + p;
      wr(p, OFF_TX_LAT, tl);
      fl = 16'h0000;
      for (int m = 0; m < 4; m++)
      begin
        e = 32'h0001_ff80 + m + tl;
        hi = (m == 0) ? OFF_SYNC_HI : (m == 3) ? OFF_PRSP_HI : OFF_DREQ_HI;
        fl |= (m == 0) ? 16'h8000 : (m == 3) ? 16'h2000 : 16'h4000;
        i_ptpts_link_partner.send_tx(p - 1, msgs[m], 32'h0001_ff80 + m);
        repeat (2) @(posedge ref_clk);
        rdchk(p, hi, {16'h0000, e[31:16]});
        rdchk(p, hi + 12'h002, {16'h0000, e[15:0]});
        rdchk(p, OFF_FLAG, {16'h0000, fl});
      end
      i_ptpts_link_partner.send_tx(p - 1, 4'h8, 32'h0bad_0000);
      repeat (2) @(posedge ref_clk);
      rdchk(p, OFF_SYNC_LO, {16'h0000, 16'(32'h0001_ff80 + tl)});
      check(ptp_summary[p - 1], 1'b1);
      rdchk(p, OFF_SUMMARY, 32'h1);
      avs_byteenable <= 4'h1;
      wr(p, OFF_FLAG, 32'h0000_e000);
      avs_byteenable <= 4'hf;
      rdchk(p, OFF_FLAG, 32'h0000_e000);
      wr(p, OFF_FLAG, 32'h0000_4000);
      rdchk(p, OFF_FLAG, 32'h0000_a000);
      wr(p, OFF_FLAG, 32'h0000_a000);
      rdchk(p, OFF_FLAG, 32'h0);
      repeat (2) @(posedge ref_clk);
      check(ptp_summary[p - 1], 1'b0);
    end
    // receive compensation against the latency written above
    for (int p = 1; p <= NP; p++)
    begin
      i_ptpts_link_partner.send_rx(p - 1, 32'h0002_0000);
      #1;
      check(rx_ts_wire_valid[p - 1], 1'b1);
      check(rx_ts_wire[p - 1], 32'h0002_0000 - (32'h0000_a5a0 + p));
    end
    // correction field, both signs, both directions, every message type
    for (int a = 0; a < 2; a++)
    begin
      asym = (a == 1) ? 16'h8064 : 16'h0064;
      wr(1, OFF_ASYM, {16'h0000, asym});
      s = asym[15] ? -int'(asym[14:0]) : int'(asym[14:0]);
      for (int k = 0; k < 8; k++)
      begin
        d = 0;
        if (k < 4 && (msgs[k % 4] == MSG_SYNC || msgs[k % 4] == MSG_PDELAY_RSP))
          d = s;
        if (k >= 4 && (msgs[k % 4] == MSG_DELAY_REQ || msgs[k % 4] == MSG_PDELAY_REQ))
          d = -s;
        i_ptpts_link_partner.send_cf(0, k >= 4, msgs[k % 4], 64'h0000_0005_0000_0000);
        #1;
        check(cf_out_valid[0], 1'b1);
        check(cf_out[0], 64'h0000_0005_0000_0000 + 64'(longint'(d) * 65536));
      end
    end
    give_verdict();
  end
endmodule
